//--- logic/armp_rx.sv
// receiving station: async frame receiver with id-wait filtering
`timescale 1ns/100ps
// Summary of operation
// - detect start, shift frame, check parity, stop
// - full still set: overrun, keep full, drop
// - any error flag with enable raises error irq
// - parity mismatch sets flag, data still stored
// - low stop bit sets framing flag, stored
// - clean frame stores data, sets full, irq
// - errored frame leaves full flag unchanged
// - no new frame while error flags set
// - software clears all flags before resuming
// - overrun plus others: set all, drop data
// - framing plus parity: both set, stored
// - extra bit one is id, zero data
// - id wait blocks data frames entirely
// - id frame: status set, wait cleared, irq
// - mp format ignores parity setting
// - sender sets id bit per frame
// - sender sends id first, then data
// - software compares id, re-arms wait
// - software reads data before next frame
// - sixteen ticks per bit, sample eighth
// - seven/eight data, optional bit, stops
// - idle mark, fall to space starts
module armp_rx (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  armp_if.rx_end          link,
  input  wire logic       i_rx_enable,
  input  wire logic       i_seven_bit,
  input  wire logic       i_parity_en,
  input  wire logic       i_parity_odd,
  input  wire logic       i_mp_format,
  input  wire logic       i_rx_irq_enable,
  input  wire logic       i_id_wait_set,
  input  wire logic       i_clr_overrun,
  input  wire logic       i_clr_framing,
  input  wire logic       i_clr_parity,
  input  wire logic       i_clr_full,
  output logic      [7:0] o_rx_data_reg,
  output logic            o_rx_full_flag,
  output logic            o_overrun_flag,
  output logic            o_framing_err_flag,
  output logic            o_parity_err_flag,
  output logic            o_rx_id_bit_status,
  output logic            o_id_wait_enable,
  output logic            o_rx_error_irq,
  output logic            o_rx_data_irq
);
  // ************************************************************
  // line synchroniser and basic clock
  // ************************************************************
  logic       sync1_q;
  logic       sync2_q;
  logic       prev_q;
  logic [3:0] div_q;

  wire tick = div_q == armp_pkg::DIV_LAST;
  // edge detector looks only at the second stage
  wire fall = prev_q & ~sync2_q;

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      sync1_q <= armp_pkg::LINE_MARK;
      sync2_q <= armp_pkg::LINE_MARK;
      prev_q  <= armp_pkg::LINE_MARK;
      div_q   <= '0;
    end
    else
    begin
      sync1_q <= link.serial_line;
      sync2_q <= sync1_q;
      prev_q  <= sync2_q;
      div_q   <= tick ? 4'h0 : div_q + 4'h1;
    end
  end

  // ************************************************************
  // frame state machine
  // ************************************************************
  armp_pkg::armp_rx_state_e state_q;
  armp_pkg::armp_rx_state_e state_d;
  logic [3:0] phase_q;
  logic [3:0] phase_d;
  logic [2:0] bcnt_q;
  logic [2:0] bcnt_d;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic       ext_q;
  logic       ext_d;
  logic       done;
  logic       ovr_q;
  logic       fer_q;
  logic       per_q;

  wire       any_err  = ovr_q | fer_q | per_q;
  // mid-bit: eighth basic-clock pulse after the falling edge
  wire       sample   = tick & (phase_q == armp_pkg::SAMPLE_PHASE);
  wire       has_ext  = i_mp_format | i_parity_en;
  wire [2:0] last_bit = i_seven_bit ? armp_pkg::LAST_BIT_7
                                    : armp_pkg::LAST_BIT_8;

  always_comb
  begin
    state_d = state_q;
    phase_d = (state_q == armp_pkg::RX_IDLE) ? 4'h0 : phase_q + 4'(tick);
    bcnt_d  = bcnt_q;
    shift_d = shift_q;
    ext_d   = ext_q;
    done    = 1'b0;
    unique case (state_q)
      armp_pkg::RX_IDLE:
      begin
        // held off while any error flag stands
        if (i_rx_enable & ~any_err & fall)
        begin
          state_d = armp_pkg::RX_START;
        end
      end
      armp_pkg::RX_START:
      begin
        if (sample)
        begin
          // a high level mid-start is a glitch, not a frame
          state_d = sync2_q ? armp_pkg::RX_IDLE : armp_pkg::RX_DATA;
          bcnt_d  = 3'h0;
        end
      end
      armp_pkg::RX_DATA:
      begin
        if (sample)
        begin
          shift_d = {sync2_q, shift_q[7:1]};
          bcnt_d  = bcnt_q + 3'h1;
          if (bcnt_q == last_bit)
          begin
            state_d = has_ext ? armp_pkg::RX_EXTRA : armp_pkg::RX_STOP;
          end
        end
      end
      armp_pkg::RX_EXTRA:
      begin
        if (sample)
        begin
          ext_d   = sync2_q;
          state_d = armp_pkg::RX_STOP;
        end
      end
      armp_pkg::RX_STOP:
      begin
        // only the first stop bit is checked; a second one is idle time
        if (sample)
        begin
          done    = 1'b1;
          state_d = armp_pkg::RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      state_q <= armp_pkg::RX_IDLE;
      phase_q <= '0;
      bcnt_q  <= '0;
      shift_q <= '0;
      ext_q   <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      phase_q <= phase_d;
      bcnt_q  <= bcnt_d;
      shift_q <= shift_d;
      ext_q   <= ext_d;
    end
  end

  // ************************************************************
  // frame evaluation and status
  // ************************************************************
  logic [7:0] data_q;
  logic       full_q;
  logic       id_bit_q;
  logic       id_wait_q;
  logic       err_irq_q;
  logic       data_irq_q;

  wire [7:0] rx_word  = i_seven_bit ? {1'b0, shift_q[7:1]} : shift_q;
  wire       id_frame = i_mp_format & ext_q;
  wire       skip     = i_mp_format & id_wait_q & ~ext_q;
  wire       take     = done & ~skip;
  wire       fer_hit  = take & ~sync2_q;
  // parity is not checked in mp format
  wire       per_hit  = take & i_parity_en & ~i_mp_format
                        & (^rx_word ^ ext_q ^ i_parity_odd);
  wire       ovr_hit  = take & full_q;
  wire       load     = take & ~full_q;
  wire       clean    = load & ~fer_hit & ~per_hit;
  // hardware set wins over a same-cycle software clear
  wire       ovr_d    = ovr_hit | (ovr_q & ~i_clr_overrun);
  wire       fer_d    = fer_hit | (fer_q & ~i_clr_framing);
  wire       per_d    = per_hit | (per_q & ~i_clr_parity);
  // reading software clears full before the next frame ends
  wire       full_d   = clean | (full_q & ~i_clr_full);
  // software re-arms the wait after an id mismatch
  wire       wait_d   = i_id_wait_set
                        | (id_wait_q & ~(take & id_frame));

  assign o_rx_data_reg      = data_q;
  assign o_rx_full_flag     = full_q;
  assign o_overrun_flag     = ovr_q;
  assign o_framing_err_flag = fer_q;
  assign o_parity_err_flag  = per_q;
  assign o_rx_id_bit_status = id_bit_q;
  assign o_id_wait_enable   = id_wait_q;
  assign o_rx_error_irq     = err_irq_q;
  assign o_rx_data_irq      = data_irq_q;

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      data_q     <= armp_pkg::RX_DATA_RST;
      full_q     <= 1'b0;
      ovr_q      <= 1'b0;
      fer_q      <= 1'b0;
      per_q      <= 1'b0;
      id_bit_q   <= 1'b0;
      id_wait_q  <= 1'b0;
      err_irq_q  <= 1'b0;
      data_irq_q <= 1'b0;
    end
    else
    begin
      data_q     <= load ? rx_word : data_q;
      full_q     <= full_d;
      ovr_q      <= ovr_d;
      fer_q      <= fer_d;
      per_q      <= per_d;
      id_bit_q   <= (take & i_mp_format) ? ext_q : id_bit_q;
      id_wait_q  <= wait_d;
      err_irq_q  <= i_rx_irq_enable & (ovr_d | fer_d | per_d);
      data_irq_q <= i_rx_irq_enable & full_d;
    end
  end
endmodule : armp_rx

//--- pkg/armp_pkg.sv
// shared constants and types for the multiprocessor async serial link
package armp_pkg;

  // ************************************************************
  // clocking
  // ************************************************************
  localparam int unsigned MCLK_HZ        = 10_000_000;
  localparam int unsigned BIT_RATE_BPS   = 62_500;
  localparam int unsigned OVERSAMPLE     = 16;
  localparam int unsigned DIV_CYCLES     = MCLK_HZ / (OVERSAMPLE * BIT_RATE_BPS);
  localparam logic [3:0]  DIV_LAST       = 4'(DIV_CYCLES - 1);
  localparam logic [3:0]  SAMPLE_PHASE   = 4'h7;
  localparam logic [3:0]  BIT_LAST_PHASE = 4'hf;

  // ************************************************************
  // frame and buffer shape
  // ************************************************************
  localparam int          DATA_W         = 8;
  localparam int          FIFO_DEPTH     = 4;
  localparam int          FIFO_W         = DATA_W + 1;
  localparam logic [3:0]  BASE_FRAME_LEN = 4'h9;
  localparam logic [2:0]  LAST_BIT_7     = 3'h6;
  localparam logic [2:0]  LAST_BIT_8     = 3'h7;

  // ************************************************************
  // reset values
  // ************************************************************
  localparam logic        LINE_MARK      = 1'b1;
  localparam logic [7:0]  RX_DATA_RST    = 8'h00;
  localparam logic [10:0] TX_SHIFT_RST   = 11'h7ff;

  // ************************************************************
  // states
  // ************************************************************
  typedef enum logic [2:0] {
    RX_IDLE,
    RX_START,
    RX_DATA,
    RX_EXTRA,
    RX_STOP
  } armp_rx_state_e;

  typedef enum logic {
    TX_IDLE,
    TX_SEND
  } armp_tx_state_e;

endpackage : armp_pkg

//--- pkg/armp_if.sv
// serial line shared by the sending station and the receiver
`timescale 1ns/100ps
interface armp_if;
  logic serial_line;

  modport tx_end (output serial_line);
  modport rx_end (input  serial_line);
endinterface : armp_if

//--- logic/armp_fifo.sv
// small word fifo with valid/ready on both sides
`timescale 1ns/100ps
module armp_fifo #(
  parameter int WIDTH = armp_pkg::FIFO_W,
  parameter int DEPTH = armp_pkg::FIFO_DEPTH
) (
  input  wire logic             i_mclk,
  input  wire logic             i_rst,
  input  wire logic             i_valid,
  input  wire logic [WIDTH-1:0] i_data,
  output logic                  o_ready,
  output logic                  o_valid,
  output logic      [WIDTH-1:0] o_data,
  input  wire logic             i_ready
);
  // depth must be a power of two so the pointers wrap on their own
  localparam int PW = $clog2(DEPTH);
  localparam int CW = PW + 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [PW-1:0]    wp_q;
  logic [PW-1:0]    rp_q;
  logic [CW-1:0]    count_q;
  logic [CW-1:0]    count_d;
  logic             ready_q;
  logic             valid_q;
  wire              push = i_valid & ready_q;
  wire              pop  = valid_q & i_ready;

  assign count_d = count_q + CW'(push) - CW'(pop);
  assign o_ready = ready_q;
  assign o_valid = valid_q;
  assign o_data  = mem_q[rp_q];

  always_ff @(posedge i_mclk)
  begin
    if (push)
    begin
      mem_q[wp_q] <= i_data;
    end
  end

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      wp_q    <= '0;
      rp_q    <= '0;
      count_q <= '0;
      ready_q <= 1'b0;
      valid_q <= 1'b0;
    end
    else
    begin
      wp_q    <= wp_q + PW'(push);
      rp_q    <= rp_q + PW'(pop);
      count_q <= count_d;
      ready_q <= count_d != CW'(DEPTH);
      valid_q <= count_d != '0;
    end
  end
endmodule : armp_fifo

//--- logic/armp_tx.sv
// sending station: queues words and shifts frames onto the line
`timescale 1ns/100ps
module armp_tx (
  input  wire logic       i_mclk,
  input  wire logic       i_rst,
  armp_if.tx_end          link,
  input  wire logic       i_valid,
  input  wire logic [7:0] i_data,
  input  wire logic       i_tx_id_bit_ctrl,
  input  wire logic       i_seven_bit,
  input  wire logic       i_parity_en,
  input  wire logic       i_parity_odd,
  input  wire logic       i_mp_format,
  input  wire logic       i_two_stop,
  output logic            o_ready,
  output logic            o_busy
);
  // ************************************************************
  // word queue
  // ************************************************************
  logic                          f_valid;
  logic [armp_pkg::FIFO_W-1:0]   f_word;
  logic                          pop;

  // each queued word carries its own id bit, sent in queue order
  armp_fifo u_fifo (
    .i_mclk  (i_mclk),
    .i_rst   (i_rst),
    .i_valid (i_valid),
    .i_data  ({i_tx_id_bit_ctrl, i_data}),
    .o_ready (o_ready),
    .o_valid (f_valid),
    .o_data  (f_word),
    .i_ready (pop)
  );

  // ************************************************************
  // frame build and shift
  // ************************************************************
  armp_pkg::armp_tx_state_e state_q;
  armp_pkg::armp_tx_state_e state_d;
  logic [3:0]  div_q;
  logic [3:0]  phase_q;
  logic [3:0]  left_q;
  logic [10:0] sr_q;
  logic        line_q;
  logic        busy_q;

  wire       tick    = div_q == armp_pkg::DIV_LAST;
  wire       bit_end = tick & (phase_q == armp_pkg::BIT_LAST_PHASE);
  wire [7:0] d       = f_word[7:0];
  wire       has_ext = i_mp_format | i_parity_en;
  wire       par     = (i_seven_bit ? ^d[6:0] : ^d) ^ i_parity_odd;
  // mp format overrides the parity setting
  wire       ext     = i_mp_format ? f_word[8] : (i_parity_en ? par : 1'b1);
  wire [9:0] body    = i_seven_bit ? {2'b11, ext, d[6:0]}
                                   : {1'b1, ext, d};
  // start, data, optional extra bit, one or two stops
  // base is the shortest frame (start, seven data, one stop); a frame one
  // period short would leave a one-cycle stop before a queued start
  wire [3:0] len     = armp_pkg::BASE_FRAME_LEN + {3'h0, ~i_seven_bit}
                       + {3'h0, has_ext} + {3'h0, i_two_stop};
  wire       start   = (state_q == armp_pkg::TX_IDLE) & f_valid;
  wire       last    = (state_q == armp_pkg::TX_SEND) & bit_end
                       & (left_q == 4'h1);

  assign pop     = start;
  assign state_d = start ? armp_pkg::TX_SEND
                 : (last ? armp_pkg::TX_IDLE : state_q);
  assign link.serial_line = line_q;
  assign o_busy  = busy_q;

  always_ff @(posedge i_mclk)
  begin
    if (i_rst)
    begin
      state_q <= armp_pkg::TX_IDLE;
      div_q   <= '0;
      phase_q <= '0;
      left_q  <= '0;
      sr_q    <= armp_pkg::TX_SHIFT_RST;
      line_q  <= armp_pkg::LINE_MARK; // idle at mark
      busy_q  <= 1'b0;
    end
    else
    begin
      state_q <= state_d;
      div_q   <= tick ? 4'h0 : div_q + 4'h1;
      busy_q  <= state_d == armp_pkg::TX_SEND;
      if (start)
      begin
        sr_q    <= {body, 1'b0};
        line_q  <= 1'b0;
        left_q  <= len;
        phase_q <= '0;
      end
      else if (state_q == armp_pkg::TX_SEND)
      begin
        phase_q <= phase_q + 4'(tick);
        if (bit_end)
        begin
          // ones shift in so the line returns to mark after the frame
          sr_q   <= {1'b1, sr_q[10:1]};
          line_q <= sr_q[1];
          left_q <= left_q - 4'h1;
        end
      end
    end
  end
endmodule : armp_tx

//--- test/armp_assertions.sv
// concurrent checks on the serial line and receiver outputs
`timescale 1ns/100ps
module armp_assertions (
  input wire logic       i_mclk,
  input wire logic       i_rst,
  input wire logic       serial_line,
  input wire logic       o_busy,
  input wire logic       i_rx_irq_enable,
  input wire logic [7:0] o_rx_data_reg,
  input wire logic       o_rx_full_flag,
  input wire logic       o_overrun_flag,
  input wire logic       o_framing_err_flag,
  input wire logic       o_parity_err_flag,
  input wire logic       o_rx_id_bit_status,
  input wire logic       o_id_wait_enable,
  input wire logic       o_rx_error_irq,
  input wire logic       o_rx_data_irq
);
  // ************************************************************
  // helpers
  // ************************************************************
  wire logic err_any = o_overrun_flag | o_framing_err_flag
                       | o_parity_err_flag;
  default clocking cb @(posedge i_mclk);
  endclocking
  default disable iff (i_rst);

  // ************************************************************
  // properties
  // ************************************************************
  a_err_irq_tie : assert property (
    o_rx_error_irq == ($past(i_rx_irq_enable) && err_any))
    else $error("error irq does not follow the error flags");
  a_data_irq_tie : assert property (
    o_rx_data_irq == ($past(i_rx_irq_enable) && o_rx_full_flag))
    else $error("data irq does not follow the full flag");
  a_err_keeps_full : assert property (
    $rose(err_any) && !$past(o_rx_full_flag) |-> !o_rx_full_flag)
    else $error("errored frame set the full flag");
  a_ovr_drops_data : assert property (
    $rose(o_overrun_flag) |-> $stable(o_rx_data_reg) && o_rx_full_flag)
    else $error("overrun frame changed data or full flag");
  a_start_low : assert property (
    $rose(o_busy) |-> !serial_line [*8])
    else $error("start bit not low");
  a_fall_starts : assert property (
    $fell(serial_line) |-> ##[0:2] o_busy)
    else $error("line fell outside a frame");
  a_wait_full : assert property (
    $rose(o_rx_full_flag) && $past(o_id_wait_enable)
    |-> o_rx_id_bit_status && !o_id_wait_enable)
    else $error("full set while waiting without an id frame");
  a_wait_no_err : assert property (
    $past(o_id_wait_enable) && o_id_wait_enable
    |-> !$rose(o_framing_err_flag) && !$rose(o_overrun_flag))
    else $error("error flag set while waiting for an id frame");
endmodule : armp_assertions

//--- test/async_receiver_multiproc_tb.sv
// bench: sender and receiver back to back, raw line for bad frames
`timescale 1ns/100ps
module async_receiver_multiproc_tb;
  // ************************************************************
  // signals and model state
  // ************************************************************
  logic       i_mclk = 1'b0, i_rst = 1'b1, valid = 1'b0, idb = 1'b0;
  logic       seven = 1'b0, pen = 1'b0, podd = 1'b0, mp = 1'b0;
  logic       two = 1'b0, irqen = 1'b0, wset = 1'b0, clr = 1'b0;
  logic       use_raw = 1'b0, raw_line = 1'b1, rxen = 1'b1;
  logic [7:0] din = 8'h00, rdata, e_d = 8'h00;
  logic       rdy, busy, full, ovr, framing_err_flag, parity_err_flag, stat, wt, eirq, dirq;
  logic       e_full = 1'b0, e_ovr = 1'b0, e_fer = 1'b0, e_per = 1'b0;
  logic       e_st = 1'b0, e_wt = 1'b0;
  int         fail_count = 0, total_checks = 0, cyc = 0;
  logic [7:0] q[$];
  // raw line lets bad frames reach the receiver; tx cannot make them
  armp_if lnk_a ();
  armp_if lnk_r ();
  assign lnk_r.serial_line = use_raw ? raw_line : lnk_a.serial_line;

  armp_tx i_armp_tx (.i_mclk(i_mclk), .i_rst(i_rst), .link(lnk_a.tx_end),
    .i_valid(valid), .i_data(din), .i_tx_id_bit_ctrl(idb),
    .i_seven_bit(seven), .i_parity_en(pen), .i_parity_odd(podd),
    .i_mp_format(mp), .i_two_stop(two), .o_ready(rdy), .o_busy(busy));
  armp_rx i_armp_rx (.i_mclk(i_mclk), .i_rst(i_rst), .link(lnk_r.rx_end),
    .i_rx_enable(rxen), .i_seven_bit(seven), .i_parity_en(pen),
    .i_parity_odd(podd), .i_mp_format(mp), .i_rx_irq_enable(irqen),
    .i_id_wait_set(wset), .i_clr_overrun(clr), .i_clr_framing(clr),
    .i_clr_parity(clr), .i_clr_full(clr), .o_rx_data_reg(rdata),
    .o_rx_full_flag(full), .o_overrun_flag(ovr), .o_framing_err_flag(framing_err_flag),
    .o_parity_err_flag(parity_err_flag), .o_rx_id_bit_status(stat),
    .o_id_wait_enable(wt), .o_rx_error_irq(eirq), .o_rx_data_irq(dirq));
  armp_assertions i_armp_assertions (.i_mclk(i_mclk), .i_rst(i_rst),
    .serial_line(lnk_a.serial_line), .o_busy(busy),
    .i_rx_irq_enable(irqen), .o_rx_data_reg(rdata),
    .o_rx_full_flag(full), .o_overrun_flag(ovr), .o_framing_err_flag(framing_err_flag),
    .o_parity_err_flag(parity_err_flag), .o_rx_id_bit_status(stat),
    .o_id_wait_enable(wt), .o_rx_error_irq(eirq), .o_rx_data_irq(dirq));

  // ************************************************************
  // tasks
  // ************************************************************
  task automatic cmp(input string nm, input logic [7:0] exp, got);
    total_checks++;
    if (got !== exp)
    begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", nm, exp, got);
    end
  endtask : cmp

  task automatic chk();
    cmp("rx_data", e_d, rdata);
    cmp("full", e_full, full);
    cmp("overrun", e_ovr, ovr);
    cmp("framing", e_fer, framing_err_flag);
    cmp("parity", e_per, parity_err_flag);
    cmp("id_status", e_st, stat);
    cmp("id_wait", e_wt, wt);
    cmp("error_irq", irqen & (e_ovr | e_fer | e_per), eirq);
    cmp("data_irq", irqen & e_full, dirq);
  endtask : chk

  task automatic mdl(input logic [7:0] d, input logic fe, pe, ext);
    if (!rxen) return;
    if (e_ovr | e_fer | e_per) return;
    if (mp & e_wt & !ext) return;
    if (mp) e_st = ext;
    if (mp & ext) e_wt = 1'b0;
    e_ovr = e_full;
    e_fer = fe;
    e_per = pe & !mp;
    if (!e_full) e_d = d;
    e_full = e_full | !(e_fer | e_per);
  endtask : mdl

  task automatic push(input logic [7:0] d, input logic ext);
    int n;
    @(negedge i_mclk);
    valid = 1'b1;
    din = d;
    idb = ext;
    for (n = 0; n < 20000 && rdy !== 1'b1; n++) @(negedge i_mclk);
    @(negedge i_mclk);
    valid = 1'b0;
  endtask : push

  // busy may drop a cycle between queued frames, so wait for a quiet run
  task automatic drain();
    int n, k;
    k = 0;
    repeat (4) @(negedge i_mclk);
    for (n = 0; n < 20000 && k < 8; n++)
    begin
      @(negedge i_mclk);
      k = (busy === 1'b0) ? k + 1 : 0;
    end
    repeat (5) @(negedge i_mclk);
  endtask : drain

  task automatic clear();
    @(negedge i_mclk);
    clr = 1'b1;
    @(negedge i_mclk);
    clr = 1'b0;
    {e_full, e_ovr, e_fer, e_per} = 4'h0;
    @(negedge i_mclk);
    chk();
  endtask : clear

  task automatic arm();
    @(negedge i_mclk);
    wset = 1'b1;
    @(negedge i_mclk);
    wset = 1'b0;
    e_wt = 1'b1;
  endtask : arm

  task automatic sendw(input logic [7:0] d, input logic ext);
    int n;
    push(d, ext);
    for (n = 0; n < 20 && lnk_a.serial_line; n++) @(negedge i_mclk);
    repeat (80) @(negedge i_mclk);
    cmp("start_bit", 8'h00, lnk_a.serial_line);
    for (n = 0; n < (seven ? 7 : 8); n++)
    begin
      repeat (160) @(negedge i_mclk);
      cmp("data_bit", d[n], lnk_a.serial_line);
    end
    drain();
    mdl(seven ? d & 8'h7f : d, 1'b0, 1'b0, ext);
    chk();
  endtask : sendw

  task automatic raw(input logic [7:0] d, input logic flip, stp);
    logic [10:0] b;
    int i;
    b = {stp, ^d ^ flip, d, 1'b0};
    for (i = 0; i < 11; i++)
    begin
      @(negedge i_mclk);
      raw_line = b[i];
      repeat (159) @(negedge i_mclk);
    end
    raw_line = 1'b1;
    repeat (200) @(negedge i_mclk);
    mdl(d, !stp, flip, 1'b0);
    chk();
  endtask : raw

  task automatic give_verdict();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : give_verdict

  // ************************************************************
  // clock, timeout and sequence
  // ************************************************************
  initial
  begin
    forever #50 i_mclk = ~i_mclk;
  end

  always @(posedge i_mclk)
  begin
    cyc <= cyc + 1;
    if (cyc == 90000)
    begin
      fail_count++;
      $display("ERROR timeout expected finish seen %0d cycles", cyc);
      give_verdict();
    end
  end

  initial
  begin
    logic [1:0] cs[6];
    int f;
    cs = '{2'b11, 2'b00, 2'b10, 2'b01, 2'b00, 2'b11};
    void'($urandom(25580));
    repeat (2) @(negedge i_mclk);
    i_rst = 1'b0;
    repeat (3) @(negedge i_mclk);
    cmp("idle_line", 8'h01, lnk_a.serial_line);
    chk();
    for (f = 0; f < 8; f++)
    begin
      {podd, pen, seven} = 3'(f);
      two = f[0] ^ f[1];
      irqen = 1'($urandom);
      sendw(8'($urandom), 1'b0);
      clear();
    end
    $display("format test done");
    {podd, pen, seven, two, irqen} = 5'h01;
    for (f = 0; f < 6; f++)
    begin
      q.push_back(8'($urandom));
      push(q[f], 1'b0);
      if (f == 4) @(negedge i_mclk);
      if (f == 4) cmp("ready_full", 8'h00, rdy);
    end
    drain();
    while (q.size() > 0) mdl(q.pop_front(), 1'b0, 1'b0, 1'b0);
    chk();
    clear();
    $display("overrun test done");
    pen = 1'b1;
    use_raw = 1'b1;
    for (f = 0; f < 6; f++)
    begin
      raw(8'($urandom), cs[f][1], cs[f][0]);
      if (f != 3 && f != 4) clear();
    end
    use_raw = 1'b0;
    $display("error test done");
    {mp, pen, irqen} = 3'h7;
    arm();
    sendw(8'($urandom), 1'b0);
    sendw(8'h5a, 1'b1);
    clear();
    sendw(8'($urandom), 1'b0);
    clear();
    // foreign id: no match, so software re-arms and the data is skipped
    sendw(8'hc3, 1'b1);
    if (rdata !== 8'h5a) arm();
    clear();
    sendw(8'($urandom), 1'b0);
    // a disabled receiver ignores even an id frame
    rxen = 1'b0;
    sendw(8'($urandom), 1'b1);
    rxen = 1'b1;
    $display("multiprocessor test done");
    give_verdict();
  end
endmodule : async_receiver_multiproc_tb
